// *** src/sca_pkg.sv ***
/*
 Shared constants and carrier types for the switch configuration applier.
 Assumes a single 20 MHz core clock; no other context.
*/
package sca_pkg;
    // Command opcodes
    typedef enum logic [2:0] {
        SCA_OP_OR = 3'h0,
        SCA_OP_AND = 3'h1,
        SCA_OP_ROUTE = 3'h2,
        SCA_OP_TIMEOUT = 3'h3,
        SCA_OP_SPEED = 3'h4,
        SCA_OP_TAP = 3'h5
    } sca_op_t;

    // Switch register access kinds
    typedef enum logic [1:0] {
        SCA_SW_READ = 2'h0,
        SCA_SW_WRITE = 2'h1,
        SCA_SW_ROUTE = 2'h2,
        SCA_SW_TAP = 2'h3
    } sca_sw_kind_t;

    // Sequencer states, Gray along the usual path except the WRW to IDLE return, which flips two bits
    typedef enum logic [2:0] {
        SCA_IDLE = 3'b000,
        SCA_RD = 3'b001,
        SCA_RDW = 3'b011,
        SCA_WR = 3'b010,
        SCA_WRW = 3'b110,
        SCA_INIT = 3'b111
    } sca_state_t;

    localparam int SCA_PORTS = 12;
    localparam int SCA_LANES = 4;
    localparam int SCA_ROUTE_MAX = 16;
    localparam logic [3:0] SCA_PORT_LAST = 4'hb;
    localparam logic [4:0] SCA_CNT_RESET = 5'h00;
    localparam logic [23:0] SCA_TMO_RESET = 24'hffffff;
    localparam logic [23:0] SCA_TMO_DEFAULT = 24'h00008e;
    localparam int SCA_TMO_UNIT_NS = 352;
    localparam logic [2:0] SCA_SPD_MAX_CODE = 3'h4;
    localparam logic [2:0] SCA_SPD_RESET = 3'h4;
    localparam logic [2:0] SCA_LANE_ALL = 3'h4;
    localparam logic [7:0] SCA_SLOT_FIRST = 8'h05;
    localparam logic [7:0] SCA_SLOT_LAST = 8'h10;
    localparam logic [7:0] SCA_SLOT_UPDATE = 8'hf0;
    localparam logic [7:0] SCA_SLOT_ILINK0 = 8'hf1;
    localparam logic [7:0] SCA_SLOT_ILINK2 = 8'hf3;
    localparam logic [7:0] SCA_SLOT_UPLINK0 = 8'hfa;
    localparam logic [7:0] SCA_SLOT_UPLINK1 = 8'hfb;
    localparam logic [31:0] SCA_TMO_OFFSET = 32'h00000120;
    localparam logic [31:0] SCA_SPEED_OFFSET = 32'h00000140;

    // Script command word
    typedef struct packed {
        sca_op_t op;
        logic dev;
        logic [31:0] offs;
        logic [31:0] value;
        logic [7:0] slot;
        logic [2:0] lane;
    } sca_cmd_t;

    // Switch register request
    typedef struct packed {
        sca_sw_kind_t kind;
        logic dev;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] port;
        logic [3:0] lane_mask;
    } sca_sw_req_t;
endpackage : sca_pkg

// *** src/sca_applier.sv ***
/*
 Switch configuration applier: takes script commands one at a time and
 drives the switch register request port.
 Assumes the switch answers each request with sw_done in a later cycle and
 that sw_rdata is valid with sw_done of a read.
*/
`timescale 1ns/1ps
// Summary of operation
// - OR command reads switch register, ORs value in, writes back on device 0/1.
// - AND command reads switch register, ANDs value, writes back on device 0/1.
// - Route entries are written only while electronic keying runs.
// - At most sixteen destination identifiers per port; further entries rejected.
// - Route output port must be 0 through 11.
// - Link timeout counts 352 ns units; reset value 0xffffff.
// - With script configuration disabled, block loads timeout 0x8e itself.
// - Speed codes 0..4 apply to the port facing the slot identifier.
// - Agreed speed is minimum of configured maximum and peer link type extension.
// - Configured speed never raises a port above its hardware maximum.
// - Slots 5..16, 240, 241..243, 250..251 map to switch ports.
// - Precursor tap 5-bit value; lane code 4 writes all four lanes.
module sca_applier (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic script_cfg_en,
    input wire logic keying_active,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sca_pkg::sca_cmd_t cmd,
    output logic cmd_done,
    output logic cmd_reject,
    output logic sw_req_valid,
    output sca_pkg::sca_sw_req_t sw_req,
    input wire logic sw_done,
    input wire logic [31:0] sw_rdata,
    input wire logic [7:0] speed_slot,
    input wire logic [2:0] peer_link_type_extension,
    input wire logic [2:0] hw_max_speed,
    output logic [2:0] agreed_speed,
    output logic [23:0] link_timeout
);
    sca_pkg::sca_state_t state_q, state_d;
    sca_pkg::sca_cmd_t cmd_q, cmd_d;
    sca_pkg::sca_sw_req_t req_q, req_d;
    logic done_q, done_d, rej_q, rej_d;
    logic [23:0] tmo_q, tmo_d;
    logic [2:0] spd_q [sca_pkg::SCA_PORTS];
    logic [4:0] rcnt_q [sca_pkg::SCA_PORTS];
    logic [2:0] agreed_q, agreed_d;
    logic map_ok, spd_map_ok, route_ok;
    logic [3:0] map_port, spd_port;
    logic [2:0] cfg_spd, cap_spd;

    // Slot identifier to switch port
    function automatic logic [4:0] slot_to_port(input logic [7:0] s);
        logic [7:0] t;
        t = 8'h00;
        slot_to_port = 5'h10;
        if (s >= sca_pkg::SCA_SLOT_FIRST && s <= sca_pkg::SCA_SLOT_LAST) begin
            t = s - sca_pkg::SCA_SLOT_FIRST;
            slot_to_port = {1'b0, t[3:0]};
        end else if (s == sca_pkg::SCA_SLOT_UPDATE) begin
            slot_to_port = 5'h00;
        end else if (s >= sca_pkg::SCA_SLOT_ILINK0 && s <= sca_pkg::SCA_SLOT_ILINK2) begin
            t = s - sca_pkg::SCA_SLOT_ILINK0;
            slot_to_port = {1'b0, 4'h8 + t[3:0]};
        end else if (s == sca_pkg::SCA_SLOT_UPLINK0 || s == sca_pkg::SCA_SLOT_UPLINK1) begin
            slot_to_port = {1'b0, 4'ha + {3'h0, s[0]}};
        end
    endfunction : slot_to_port

    // Port lookup for the current command and the keying query
    always_comb begin
        logic [4:0] p;
        logic [4:0] q;
        p = slot_to_port(cmd.slot);
        q = slot_to_port(speed_slot);
        map_ok = ~p[4];
        map_port = p[3:0];
        spd_map_ok = ~q[4];
        spd_port = q[3:0];
        route_ok = keying_active && (cmd.offs[3:0] <= sca_pkg::SCA_PORT_LAST)
            && (cmd.offs[31:4] == 28'h0)
            && (rcnt_q[cmd.offs[3:0]] < 5'(sca_pkg::SCA_ROUTE_MAX));
    end

    // Speed agreement during keying
    always_comb begin
        cfg_spd = spd_map_ok ? spd_q[spd_port] : sca_pkg::SCA_SPD_RESET;
        cap_spd = (cfg_spd < hw_max_speed) ? cfg_spd : hw_max_speed;
        agreed_d = (cap_spd < peer_link_type_extension) ? cap_spd
            : peer_link_type_extension;
    end

    // Command sequencer next state
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        req_d = req_q;
        done_d = 1'b0;
        rej_d = 1'b0;
        tmo_d = tmo_q;
        case (state_q)
            sca_pkg::SCA_INIT: begin
                req_d.kind = sca_pkg::SCA_SW_WRITE;
                req_d.addr = sca_pkg::SCA_TMO_OFFSET;
                req_d.port = 4'h0;
                req_d.lane_mask = 4'h0;
                if (!script_cfg_en) begin
                    tmo_d = sca_pkg::SCA_TMO_DEFAULT;
                    req_d.dev = 1'b0;
                    req_d.data = {8'h00, sca_pkg::SCA_TMO_DEFAULT};
                    state_d = sca_pkg::SCA_WR;
                end else begin
                    state_d = sca_pkg::SCA_IDLE;
                end
            end
            sca_pkg::SCA_IDLE: begin
                if (cmd_valid) begin
                    cmd_d = cmd;
                    req_d.dev = cmd.dev;
                    req_d.addr = cmd.offs;
                    req_d.data = cmd.value;
                    req_d.port = map_port;
                    req_d.lane_mask = 4'h0;
                    case (cmd.op)
                        sca_pkg::SCA_OP_OR, sca_pkg::SCA_OP_AND: begin
                            req_d.kind = sca_pkg::SCA_SW_READ;
                            state_d = sca_pkg::SCA_RD;
                        end
                        sca_pkg::SCA_OP_ROUTE: begin
                            req_d.kind = sca_pkg::SCA_SW_ROUTE;
                            req_d.port = cmd.offs[3:0];
                            if (route_ok) begin
                                state_d = sca_pkg::SCA_WR;
                            end else begin
                                rej_d = 1'b1;
                            end
                        end
                        sca_pkg::SCA_OP_TIMEOUT: begin
                            req_d.kind = sca_pkg::SCA_SW_WRITE;
                            req_d.addr = sca_pkg::SCA_TMO_OFFSET;
                            req_d.data = {8'h00, cmd.value[23:0]};
                            tmo_d = cmd.value[23:0];
                            state_d = sca_pkg::SCA_WR;
                        end
                        sca_pkg::SCA_OP_SPEED: begin
                            // Stored locally, applied at keying
                            done_d = map_ok && cmd.value[2:0] <= sca_pkg::SCA_SPD_MAX_CODE;
                            rej_d = !done_d;
                        end
                        sca_pkg::SCA_OP_TAP: begin
                            req_d.kind = sca_pkg::SCA_SW_TAP;
                            req_d.data = {27'h0, cmd.value[4:0]};
                            req_d.lane_mask = (cmd.lane == sca_pkg::SCA_LANE_ALL) ? 4'hf
                                : 4'(4'h1 << cmd.lane[1:0]);
                            if (map_ok && cmd.lane <= sca_pkg::SCA_LANE_ALL) begin
                                state_d = sca_pkg::SCA_WR;
                            end else begin
                                rej_d = 1'b1;
                            end
                        end
                        default: rej_d = 1'b1;
                    endcase
                end
            end
            sca_pkg::SCA_RD: state_d = sca_pkg::SCA_RDW;
            sca_pkg::SCA_RDW: begin
                if (sw_done) begin
                    req_d.kind = sca_pkg::SCA_SW_WRITE;
                    req_d.data = (cmd_q.op == sca_pkg::SCA_OP_OR) ? (sw_rdata | cmd_q.value)
                        : (sw_rdata & cmd_q.value);
                    state_d = sca_pkg::SCA_WR;
                end
            end
            sca_pkg::SCA_WR: state_d = sca_pkg::SCA_WRW;
            sca_pkg::SCA_WRW: begin
                if (sw_done) begin
                    done_d = 1'b1;
                    state_d = sca_pkg::SCA_IDLE;
                end
            end
            default: state_d = sca_pkg::SCA_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= sca_pkg::SCA_INIT;
            cmd_q <= '0;
            req_q <= '0;
            done_q <= 1'b0;
            rej_q <= 1'b0;
            tmo_q <= sca_pkg::SCA_TMO_RESET;
            agreed_q <= sca_pkg::SCA_SPD_RESET;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            req_q <= req_d;
            done_q <= done_d;
            rej_q <= rej_d;
            tmo_q <= tmo_d;
            agreed_q <= agreed_d;
        end
    end

    // Per-port speed limit and route counters
    for (genvar i = 0; i < sca_pkg::SCA_PORTS; i++) begin : g_port
        logic [2:0] spd_d;
        logic [4:0] rcnt_d;
        always_comb begin
            spd_d = spd_q[i];
            rcnt_d = rcnt_q[i];
            if (state_q == sca_pkg::SCA_IDLE && cmd_valid && map_ok && map_port == 4'(i)
                && cmd.op == sca_pkg::SCA_OP_SPEED
                && cmd.value[2:0] <= sca_pkg::SCA_SPD_MAX_CODE) begin
                spd_d = cmd.value[2:0];
            end
            if (state_q == sca_pkg::SCA_IDLE && cmd_valid && route_ok
                && cmd.op == sca_pkg::SCA_OP_ROUTE && cmd.offs[3:0] == 4'(i)) begin
                rcnt_d = rcnt_q[i] + 5'h01;
            end
        end
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                spd_q[i] <= sca_pkg::SCA_SPD_RESET;
                rcnt_q[i] <= sca_pkg::SCA_CNT_RESET;
            end else begin
                spd_q[i] <= spd_d;
                rcnt_q[i] <= rcnt_d;
            end
        end
    end

    // Outputs
    assign cmd_ready = (state_q == sca_pkg::SCA_IDLE);
    assign cmd_done = done_q;
    assign cmd_reject = rej_q;
    assign sw_req_valid = (state_q == sca_pkg::SCA_RD) || (state_q == sca_pkg::SCA_WR);
    assign sw_req = req_q;
    assign agreed_speed = agreed_q;
    assign link_timeout = tmo_q;

    // Read-modify-write: the write carries the merged value
    chk_rmw_write_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == sca_pkg::SCA_RDW && sw_done && cmd_q.op == sca_pkg::SCA_OP_OR)
        |=> sw_req.data == ($past(sw_rdata) | cmd_q.value))
        else $error("OR write-back wrong");
    chk_and_write_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == sca_pkg::SCA_RDW && sw_done && cmd_q.op == sca_pkg::SCA_OP_AND)
        |=> sw_req_valid && sw_req.data == ($past(sw_rdata) & cmd_q.value))
        else $error("AND write-back wrong");
    chk_route_keying: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sw_req_valid && sw_req.kind == sca_pkg::SCA_SW_ROUTE) |-> $past(keying_active))
        else $error("Route written outside keying");
    chk_route_port: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sw_req_valid && sw_req.kind == sca_pkg::SCA_SW_ROUTE)
        |-> sw_req.port <= sca_pkg::SCA_PORT_LAST)
        else $error("Route port out of range");
    chk_route_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cmd_valid && cmd_ready && cmd.op == sca_pkg::SCA_OP_ROUTE
        && cmd.offs[31:4] == 28'h0 && cmd.offs[3:0] <= sca_pkg::SCA_PORT_LAST
        && rcnt_q[cmd.offs[3:0]] == 5'h10) |=> cmd_reject)
        else $error("Seventeenth route accepted");
    chk_default_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($past(!rst_n) && !script_cfg_en && state_q == sca_pkg::SCA_INIT)
        |=> link_timeout == sca_pkg::SCA_TMO_DEFAULT && sw_req_valid)
        else $error("Default timeout not loaded");
    chk_speed_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> agreed_speed <= $past(hw_max_speed)
        && agreed_speed <= $past(peer_link_type_extension))
        else $error("Agreed speed above a limit");
    chk_tap_lanes: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sw_req_valid && sw_req.kind == sca_pkg::SCA_SW_TAP)
        |-> sw_req.data[31:5] == 27'h0 && sw_req.lane_mask != 4'h0)
        else $error("Tap request malformed");
    chk_one_at_time: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q != sca_pkg::SCA_IDLE) |=> $stable(cmd_q))
        else $error("Command accepted mid read-modify-write");

    // Read-modify-write steps: read of the command's register, then the merged write
    sequence s_rmw_read;
        sw_req_valid && sw_req.kind == sca_pkg::SCA_SW_READ
            && sw_req.addr == cmd_q.offs && sw_req.dev == cmd_q.dev;
    endsequence
    sequence s_rmw_write;
        sw_req_valid && sw_req.kind == sca_pkg::SCA_SW_WRITE
            && sw_req.addr == cmd_q.offs && sw_req.dev == cmd_q.dev;
    endsequence
    chk_rmw_read_req: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cmd_valid && cmd_ready
        && (cmd.op == sca_pkg::SCA_OP_OR || cmd.op == sca_pkg::SCA_OP_AND)) |=> s_rmw_read)
        else $error("Read-modify-write read missing");
    chk_rmw_pairing: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == sca_pkg::SCA_RDW && sw_done) |=> s_rmw_write)
        else $error("Read-modify-write write missing");

    // Speed commands answer in the next cycle with exactly one outcome
    chk_speed_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cmd_valid && cmd_ready && cmd.op == sca_pkg::SCA_OP_SPEED)
        |=> cmd_done != cmd_reject)
        else $error("Speed command outcome wrong");
endmodule : sca_applier

// *** tb/sca_switch_model.sv ***
/*
 Behavioural model of the switch register port facing the applier.
 Assumes the applier's clock and its synchronous active-low reset.
*/
`timescale 1ns/1ps
module sca_switch_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sw_req_valid,
    input wire sca_pkg::sca_sw_req_t sw_req,
    output logic sw_done,
    output logic [31:0] sw_rdata
);
    logic [31:0] mem [2][256];
    sca_pkg::sca_sw_req_t last_q;
    int delay = 1;
    int busy = 0;
    int nwr = 0;
    int overlaps = 0;

    initial begin
        sw_done = 1'b0;
        sw_rdata = 32'h00000000;
    end

    // Answer after delay cycles; read data toggles while not valid
    always @(posedge core_clk) begin
        sw_done <= 1'b0;
        sw_rdata <= ~sw_rdata;
        if (!rst_n) begin
            busy = 0;
        end else if (sw_req_valid) begin
            if (busy != 0) begin
                overlaps++;
            end
            last_q = sw_req;
            busy = delay;
        end else if (busy != 0) begin
            busy--;
            if (busy == 0) begin
                sw_done <= 1'b1;
                if (last_q.kind == sca_pkg::SCA_SW_READ) begin
                    sw_rdata <= mem[last_q.dev][last_q.addr[7:0]];
                end
                if (last_q.kind == sca_pkg::SCA_SW_WRITE) begin
                    mem[last_q.dev][last_q.addr[7:0]] = last_q.data;
                    nwr++;
                end
            end
        end
    end
endmodule : sca_switch_model

// *** tb/test_switch_config_applier.sv ***
/*
 Self-checking bench for the switch configuration applier.
 Assumes the behavioural switch model and one 20 MHz clock.
*/
`timescale 1ns/1ps
`define SW i_sca_switch_model
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_switch_config_applier;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic script_cfg_en = 1'b0;
    logic keying_active = 1'b0;
    logic cmd_valid = 1'b0;
    sca_pkg::sca_cmd_t cmd = '0;
    logic [7:0] speed_slot = 8'h00;
    logic [2:0] peer_link_type_extension = 3'h4;
    logic [2:0] hw_max_speed = 3'h4;
    logic cmd_ready, cmd_done, cmd_reject, sw_req_valid, sw_done;
    sca_pkg::sca_sw_req_t sw_req;
    logic [31:0] sw_rdata;
    logic [2:0] agreed_speed;
    logic [23:0] link_timeout;
    int mismatches = 0;
    int tests_run = 0;

    sca_applier i_sca_applier (.core_clk, .rst_n, .script_cfg_en, .keying_active, .cmd_valid,
        .cmd_ready, .cmd, .cmd_done, .cmd_reject, .sw_req_valid, .sw_req, .sw_done, .sw_rdata,
        .speed_slot, .peer_link_type_extension, .hw_max_speed, .agreed_speed, .link_timeout);
    sca_switch_model i_sca_switch_model (.core_clk, .rst_n, .sw_req_valid, .sw_req, .sw_done,
        .sw_rdata);

    always #25 core_clk = ~core_clk;

    task automatic finish_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Offer one command, wait for its outcome and judge done against refusal
    task automatic do_cmd(input sca_pkg::sca_op_t op, input logic dev, input logic [31:0] offs,
            input logic [31:0] value, input logic [7:0] slot, input logic [2:0] lane,
            input logic rej);
        int n;
        cmd = '{op, dev, offs, value, slot, lane};
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_done !== 1'b1 && cmd_reject !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK({cmd_done, cmd_reject}, (rej ? 2'h1 : 2'h2))
    endtask : do_cmd

    // Present a keying query and compare the agreed speed
    task automatic spd_chk(input logic [7:0] slot, input logic [2:0] peer,
            input logic [2:0] hw, input logic [2:0] exp);
        speed_slot = slot;
        peer_link_type_extension = peer;
        hw_max_speed = hw;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(agreed_speed, exp)
    endtask : spd_chk

    task automatic t_init;
        int n;
        n = 0;
        while (`SW.nwr == 0 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(cmd_ready, 1'b0)
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(cmd_ready, 1'b1)
        `CHK(`SW.mem[0][8'h20][23:0], 24'h00008e)
        `CHK(link_timeout, sca_pkg::SCA_TMO_DEFAULT)
    endtask : t_init

    // Slow switch answers; the two devices hold different contents
    task automatic t_rmw;
        `SW.delay = 3;
        `SW.mem[1][8'h10] = 32'h0000f0f0;
        `SW.mem[0][8'h10] = 32'h000080ff;
        do_cmd(sca_pkg::SCA_OP_OR, 1'b1, 32'h10, 32'h01, 8'h00, 3'h0, 1'b0);
        `CHK(`SW.mem[1][8'h10], 32'h0000f0f1)
        do_cmd(sca_pkg::SCA_OP_AND, 1'b0, 32'h10, 32'h7f, 8'h00, 3'h0, 1'b0);
        `CHK(`SW.mem[0][8'h10], 32'h0000007f)
        `CHK(`SW.mem[1][8'h10], 32'h0000f0f1)
        `CHK(`SW.overlaps, 0)
        `SW.delay = 1;
    endtask : t_rmw

    task automatic t_route;
        do_cmd(sca_pkg::SCA_OP_ROUTE, 1'b0, 32'h3, 32'h1, 8'h00, 3'h0, 1'b1);
        keying_active = 1'b1;
        do_cmd(sca_pkg::SCA_OP_ROUTE, 1'b0, 32'hc, 32'h1, 8'h00, 3'h0, 1'b1);
        do_cmd(sca_pkg::SCA_OP_ROUTE, 1'b1, 32'hb, 32'h2, 8'h00, 3'h0, 1'b0);
        `CHK({`SW.last_q.dev, `SW.last_q.port}, 5'h1b)
        `CHK(`SW.last_q.data, 32'h00000002)
        for (int i = 0; i < 16; i++) begin
            do_cmd(sca_pkg::SCA_OP_ROUTE, 1'b0, 32'h3, 32'(i), 8'h00, 3'h0, 1'b0);
        end
        `CHK(`SW.last_q.kind, sca_pkg::SCA_SW_ROUTE)
        do_cmd(sca_pkg::SCA_OP_ROUTE, 1'b0, 32'h3, 32'h20, 8'h00, 3'h0, 1'b1);
        keying_active = 1'b0;
    endtask : t_route

    // A 20 us period is 57 units of 352 ns
    task automatic t_timeout;
        do_cmd(sca_pkg::SCA_OP_TIMEOUT, 1'b0, 32'h0, 32'h39, 8'h00, 3'h0, 1'b0);
        `CHK(link_timeout, 24'h000039)
        `CHK(`SW.mem[0][8'h20][23:0], 24'h000039)
    endtask : t_timeout

    task automatic t_speed;
        spd_chk(8'h06, 3'h4, 3'h4, 3'h4);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h2, 8'h05, 3'h0, 1'b0);
        spd_chk(8'h05, 3'h3, 3'h4, 3'h2);
        spd_chk(8'h05, 3'h1, 3'h4, 3'h1);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h4, 8'h07, 3'h0, 1'b0);
        spd_chk(8'h07, 3'h4, 3'h2, 3'h2);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h3, 8'hfa, 3'h0, 1'b0);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h3, 8'hfb, 3'h0, 1'b0);
        spd_chk(8'hfa, 3'h4, 3'h4, 3'h3);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h5, 8'h05, 3'h0, 1'b1);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h1, 8'h11, 3'h0, 1'b1);
        do_cmd(sca_pkg::SCA_OP_SPEED, 1'b0, 32'h0, 32'h0, 8'hf0, 3'h0, 1'b0);
        spd_chk(8'hf0, 3'h4, 3'h4, 3'h0);
    endtask : t_speed

    task automatic t_tap;
        do_cmd(sca_pkg::SCA_OP_TAP, 1'b0, 32'h0, 32'h1f, 8'h05, 3'h4, 1'b0);
        `CHK({`SW.last_q.port, `SW.last_q.lane_mask, `SW.last_q.data[4:0]}, 13'h01ff)
        do_cmd(sca_pkg::SCA_OP_TAP, 1'b0, 32'h0, 32'h00, 8'hf3, 3'h2, 1'b0);
        `CHK({`SW.last_q.port, `SW.last_q.lane_mask}, 8'ha4)
        do_cmd(sca_pkg::SCA_OP_TAP, 1'b0, 32'h0, 32'h05, 8'hfb, 3'h0, 1'b0);
        `CHK({`SW.last_q.port, `SW.last_q.lane_mask}, 8'hb1)
        do_cmd(sca_pkg::SCA_OP_TAP, 1'b0, 32'h0, 32'h01, 8'h05, 3'h5, 1'b1);
        do_cmd(sca_pkg::SCA_OP_TAP, 1'b0, 32'h0, 32'h01, 8'h11, 3'h0, 1'b1);
        do_cmd(sca_pkg::sca_op_t'(3'h6), 1'b0, 32'h0, 32'h0, 8'h05, 3'h0, 1'b1);
    endtask : t_tap

    // Second reset with script configuration on leaves the timeout alone
    task automatic t_enabled;
        int n;
        n = `SW.nwr;
        rst_n = 1'b0;
        script_cfg_en = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        `CHK(link_timeout, sca_pkg::SCA_TMO_RESET)
        `CHK(`SW.nwr, n)
    endtask : t_enabled

    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        `CHK(link_timeout, sca_pkg::SCA_TMO_RESET)
        rst_n = 1'b1;
        t_init();
        t_rmw();
        t_route();
        t_timeout();
        t_speed();
        t_tap();
        t_enabled();
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        finish_test();
    end
endmodule : test_switch_config_applier
